// [nsrf_pkg.sv]
package nsrf_pkg;

   // ****************************************
   // Register word indices (byte address is four times the index)
   // ****************************************
   localparam logic [11:0] IDX_EXT_PORT_RX_FLAGS = 12'h0032;
   localparam logic [11:0] IDX_EXT_PORT_RX_COUNT = 12'h0033;
   localparam logic [11:0] IDX_SERIAL_RX_FLAGS   = 12'h0188;
   localparam logic [11:0] IDX_PORT1_RX_COUNT    = 12'h0189;
   localparam logic [11:0] IDX_PORT2_RX_COUNT    = 12'h018a;
   localparam logic [11:0] IDX_FRAME_CFG         = 12'h0200;
   localparam logic [11:0] IDX_PORT_CTRL         = 12'h0201;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int P1_DONE_BIT = 6;
   localparam int P1_OVF_BIT  = 7;
   localparam int P2_DONE_BIT = 14;
   localparam int P2_OVF_BIT  = 15;
   localparam int EXT_DONE_BIT = 6;
   localparam int EXT_OVF_BIT  = 7;
   localparam int CS_BIT      = 15;
   localparam int DSR_BIT     = 14;

   // ****************************************
   // Frame limits and reset values
   // ****************************************
   localparam logic [8:0]  MAX_DATA   = 9'h100;
   localparam logic [8:0]  CNT_RESET  = 9'h000;
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
   localparam int          NUM_PORTS  = 3;
   localparam logic [1:0]  PORT_EXT   = 2'h2;

   // ****************************************
   // Terminator and monitor encodings
   // ****************************************
   typedef enum logic [1:0] {
      NSRF_END_NONE = 2'h0,
      NSRF_END_CRLF = 2'h1,
      NSRF_END_BYTE = 2'h2
   } nsrf_end_t;

   localparam logic [7:0] CR_CODE = 8'h0d;
   localparam logic [7:0] LF_CODE = 8'h0a;
   localparam logic [3:0] MON_CS   = 4'h1;
   localparam logic [3:0] MON_DSR  = 4'h2;
   localparam logic [3:0] MON_BOTH = 4'h3;

   // Frame setup: start_en, start code, end mode, end code, length
   typedef struct packed {
      logic       start_en;
      logic [7:0] start_code;
      nsrf_end_t  end_mode;
      logic [7:0] end_code;
      logic [7:0] length;
   } nsrf_cfg_t;

   // Read operation request
   typedef struct packed {
      logic [15:0] ctrl;
      logic [8:0]  count;
      logic [15:0] dest;
   } nsrf_rd_req_t;

   // Destination word write
   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [15:0] data;
   } nsrf_wr_t;

endpackage

// [nsrf_rx_framer.sv]
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Read copies up to requested bytes; only bytes actually received are stored.
// - Source port comes from control operand bits 8 to 9.
// - Optional start code, any byte 00 to FF.
// - Terminator: none, CR+LF, or any single byte.
// - Without terminator, 8-bit length 1..256, 00 means 256.
// - Byte order in words follows control bits 0 to 3.
// - Fixed length: completion set when count reaches configured length.
// - Terminator mode: completion on terminator or 256 data bytes.
// - Overflow set when more bytes arrive than the frame allows.
// - Read stores from destination, clears completion, zeroes counter.
// - Restart bit clears completion and zeroes counter.
// - Clear-to-send monitoring alone puts that line in bit 15.
// - Data-set-ready monitoring alone puts that line in bit 15.
// - Both monitored: clear-to-send bit 15, data-set-ready bit 14.
// - Monitor codes 1..3 read regardless of completion, store no data.
// - Frame at most 259 bytes; count excludes start and end codes.
// - Option-board ports flush whole buffer after each read.
// - No new frame accepted until completed frame is read.
// - Count 0 clears both flags, zeroes counter, writes nothing.
// - Counter holds received bytes in binary, 0 to 256.
// - Terminator mode: overflow after 257 bytes without terminator.
module nsrf_rx_framer
   import nsrf_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // Register port
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   // Received bytes per port, one-cycle strobe
   input  wire logic [NUM_PORTS-1:0]  rx_valid,
   input  wire logic [NUM_PORTS*8-1:0] rx_byte,
   // Handshake line pins per port
   input  wire logic [NUM_PORTS-1:0]  cts_line,
   input  wire logic [NUM_PORTS-1:0]  data_set_ready_line,
   // Read operation from instruction engine
   input  wire logic                  rd_start,
   input  wire nsrf_pkg::nsrf_rd_req_t rd_req,
   output logic                       rd_done,
   output nsrf_pkg::nsrf_wr_t         mem_wr
);
   import nsrf_pkg::*;

   if (ADDR_W < 14) begin : g_addr_chk
      $error("ADDR_W too small for register map");
   end

   // ****************************************
   // State and storage
   // ****************************************
   typedef enum logic [3:0] {
      NSRF_IDLE = 4'b0001,
      NSRF_COPY = 4'b0010,
      NSRF_MON  = 4'b0100,
      NSRF_FIN  = 4'b1000
   } nsrf_st_t;

   nsrf_st_t                   st_r;
   nsrf_cfg_t                  cfg_r [NUM_PORTS];
   logic [NUM_PORTS-1:0]       restart_r;
   logic [NUM_PORTS-1:0]       done_r;
   logic [NUM_PORTS-1:0]       ovf_r;
   logic [NUM_PORTS-1:0]       in_frame_r;
   logic [NUM_PORTS-1:0]       cr_seen_r;
   logic [8:0]                 cnt_r [NUM_PORTS];
   logic [7:0]                 buf_r [NUM_PORTS][256];
   logic [NUM_PORTS-1:0]       cts_s1_r, cts_s2_r, dsr_s1_r, dsr_s2_r;
   logic [1:0]                 port_r;
   logic [15:0]                ctrl_r;
   logic [8:0]                 req_r;
   logic [8:0]                 idx_r;
   logic [15:0]                dst_r;
   logic [NUM_PORTS-1:0]       rd_clr;
   logic [NUM_PORTS-1:0]       rd_clr_ovf;

   function automatic logic [1:0] sel_port(input logic [15:0] c);
      sel_port = c[9:8];
   endfunction

   function automatic logic [8:0] frame_len(input nsrf_cfg_t c);
      frame_len = (c.length == 8'h00) ? MAX_DATA : {1'b0, c.length};
   endfunction

   function automatic logic [7:0] fetch(input logic [1:0] p, input logic [8:0] i);
      logic [7:0] b;
      b = 8'h00;
      for (int k = 0; k < NUM_PORTS; k++) begin
         if (p == 2'(k)) b = buf_r[k][i[7:0]];
      end
      fetch = b;
   endfunction

   // ****************************************
   // Register port
   // ****************************************
   logic [11:0] widx;
   assign widx = reg_addr[13:2];

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int k = 0; k < NUM_PORTS; k++) cfg_r[k] <= nsrf_cfg_t'(CFG_RESET[26:0]);
         restart_r <= '0;
      end else begin
         restart_r <= '0;
         if (reg_wr && widx == IDX_FRAME_CFG) begin
            if (reg_wdata[31:30] < 2'(NUM_PORTS)) cfg_r[reg_wdata[31:30]] <= reg_wdata[26:0];
         end else if (reg_wr && widx == IDX_PORT_CTRL) begin
            restart_r <= reg_wdata[NUM_PORTS-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         if (widx == IDX_SERIAL_RX_FLAGS) begin
            reg_rdata <= 32'h0000_0000;
            reg_rdata[P1_DONE_BIT] <= done_r[0];
            reg_rdata[P1_OVF_BIT]  <= ovf_r[0];
            reg_rdata[P2_DONE_BIT] <= done_r[1];
            reg_rdata[P2_OVF_BIT]  <= ovf_r[1];
         end else if (widx == IDX_EXT_PORT_RX_FLAGS) begin
            reg_rdata <= 32'h0000_0000;
            reg_rdata[EXT_DONE_BIT] <= done_r[2];
            reg_rdata[EXT_OVF_BIT]  <= ovf_r[2];
         end else if (widx == IDX_PORT1_RX_COUNT) begin
            reg_rdata <= {23'h00_0000, cnt_r[0]};
         end else if (widx == IDX_PORT2_RX_COUNT) begin
            reg_rdata <= {23'h00_0000, cnt_r[1]};
         end else if (widx == IDX_EXT_PORT_RX_COUNT) begin
            reg_rdata <= {23'h00_0000, cnt_r[2]};
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ****************************************
   // Handshake line synchronisers
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         cts_s1_r <= '0;
         cts_s2_r <= '0;
         dsr_s1_r <= '0;
         dsr_s2_r <= '0;
      end else begin
         cts_s1_r <= cts_line;
         cts_s2_r <= cts_s1_r;
         dsr_s1_r <= data_set_ready_line;
         dsr_s2_r <= dsr_s1_r;
      end
   end

   // ****************************************
   // Receive framing per port
   // ****************************************
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [7:0] b;
      logic       is_start, is_end_byte, is_lf_end, is_cr, clr, frm, crs;
      logic [8:0] base;
      nsrf_cfg_t  c;
      // A clear in the same cycle as a byte starts a fresh frame for that byte
      assign clr         = rd_clr[p] || restart_r[p];
      assign frm         = in_frame_r[p] && !clr;
      assign crs         = cr_seen_r[p] && !clr;
      assign base        = clr ? CNT_RESET : cnt_r[p];
      assign c           = cfg_r[p];
      assign b           = rx_byte[p*8 +: 8];
      assign is_start    = c.start_en && !frm;
      assign is_end_byte = (c.end_mode == NSRF_END_BYTE) && (b == c.end_code);
      assign is_cr       = (c.end_mode == NSRF_END_CRLF) && (b == CR_CODE);
      assign is_lf_end   = (c.end_mode == NSRF_END_CRLF) && crs && (b == LF_CODE);

      always_ff @(posedge clk) begin
         if (reset) begin
            done_r[p]     <= 1'b0;
            ovf_r[p]      <= 1'b0;
            in_frame_r[p] <= 1'b0;
            cr_seen_r[p]  <= 1'b0;
            cnt_r[p]      <= CNT_RESET;
         end else begin
            if (clr) begin
               done_r[p]     <= 1'b0;
               cnt_r[p]      <= CNT_RESET;
               in_frame_r[p] <= 1'b0;
               cr_seen_r[p]  <= 1'b0;
            end
            if (rd_clr_ovf[p]) ovf_r[p] <= 1'b0;
            if (rx_valid[p]) begin
               if (done_r[p] && !clr) begin
                  ovf_r[p] <= 1'b1;
               end else if (is_start && b == c.start_code) begin
                  in_frame_r[p] <= 1'b1;
               end else if (is_start) begin
                  in_frame_r[p] <= 1'b0;
               end else if (is_end_byte || is_lf_end) begin
                  done_r[p]     <= 1'b1;
                  in_frame_r[p] <= 1'b0;
                  cr_seen_r[p]  <= 1'b0;
               end else if (is_cr && !crs) begin
                  cr_seen_r[p]  <= 1'b1;
               end else if (base == MAX_DATA) begin
                  ovf_r[p] <= 1'b1;
               end else begin
                  buf_r[p][base[7:0]] <= b;
                  cnt_r[p]      <= base + 9'h001;
                  cr_seen_r[p]  <= 1'b0;
                  if (c.end_mode == NSRF_END_NONE &&
                      base + 9'h001 == frame_len(c)) begin
                     done_r[p] <= 1'b1;
                  end else if (c.end_mode != NSRF_END_NONE &&
                               base + 9'h001 == MAX_DATA) begin
                     done_r[p] <= 1'b1;
                  end
               end
            end
         end
      end
   end

   // ****************************************
   // Read operation engine
   // ****************************************
   logic [3:0] mon;
   assign mon = ctrl_r[7:4];

   always_ff @(posedge clk) begin
      if (reset) begin
         st_r       <= NSRF_IDLE;
         port_r     <= 2'h0;
         ctrl_r     <= 16'h0000;
         req_r      <= 9'h000;
         idx_r      <= 9'h000;
         dst_r      <= 16'h0000;
         rd_done    <= 1'b0;
         mem_wr     <= '0;
         rd_clr     <= '0;
         rd_clr_ovf <= '0;
      end else begin
         rd_done    <= 1'b0;
         mem_wr.we  <= 1'b0;
         rd_clr     <= '0;
         rd_clr_ovf <= '0;
         case (st_r)
            NSRF_IDLE: begin
               if (rd_start) begin
                  port_r <= sel_port(rd_req.ctrl);
                  ctrl_r <= rd_req.ctrl;
                  req_r  <= (rd_req.count > MAX_DATA) ? MAX_DATA : rd_req.count;
                  idx_r  <= 9'h000;
                  dst_r  <= rd_req.dest;
                  if (rd_req.ctrl[7:4] >= MON_CS && rd_req.ctrl[7:4] <= MON_BOTH) begin
                     st_r <= NSRF_MON;
                  end else if (rd_req.count == 9'h000) begin
                     rd_clr[sel_port(rd_req.ctrl)]     <= 1'b1;
                     rd_clr_ovf[sel_port(rd_req.ctrl)] <= 1'b1;
                     rd_done <= 1'b1;
                  end else begin
                     st_r <= NSRF_COPY;
                  end
               end
            end
            NSRF_COPY: begin
               if (idx_r >= req_r || idx_r >= cnt_r[port_r]) begin
                  st_r <= NSRF_FIN;
               end else begin
                  mem_wr.we   <= 1'b1;
                  mem_wr.addr <= dst_r + 16'(idx_r[8:1]);
                  if (idx_r + 9'h001 < req_r && idx_r + 9'h001 < cnt_r[port_r]) begin
                     // Order 0 puts the first byte high, any other order low
                     mem_wr.data <= (ctrl_r[3:0] == 4'h0)
                        ? {fetch(port_r, idx_r), fetch(port_r, idx_r + 9'h001)}
                        : {fetch(port_r, idx_r + 9'h001), fetch(port_r, idx_r)};
                  end else begin
                     mem_wr.data <= (ctrl_r[3:0] == 4'h0)
                        ? {fetch(port_r, idx_r), 8'h00}
                        : {8'h00, fetch(port_r, idx_r)};
                  end
                  idx_r <= idx_r + 9'h002;
               end
            end
            NSRF_MON: begin
               mem_wr.we   <= 1'b1;
               mem_wr.addr <= dst_r;
               mem_wr.data <= 16'h0000;
               if (mon == MON_CS) begin
                  mem_wr.data[CS_BIT] <= cts_s2_r[port_r];
               end else if (mon == MON_DSR) begin
                  mem_wr.data[CS_BIT] <= dsr_s2_r[port_r];
               end else begin
                  mem_wr.data[CS_BIT]  <= cts_s2_r[port_r];
                  mem_wr.data[DSR_BIT] <= dsr_s2_r[port_r];
               end
               st_r <= NSRF_FIN;
            end
            NSRF_FIN: begin
               if (!(mon >= MON_CS && mon <= MON_BOTH)) begin
                  rd_clr[port_r] <= 1'b1;
               end
               rd_done <= 1'b1;
               st_r    <= NSRF_IDLE;
            end
            default: st_r <= NSRF_IDLE;
         endcase
      end
   end

endmodule

// [nsrf_rx_framer_sva.sv]
`timescale 1ns/1ps
module nsrf_rx_framer_sva #(
   parameter int ADDR_W = 14
) (
   // Clock and reset
   input wire logic                           clk,
   input wire logic                           reset,
   // Register port
   input wire logic [ADDR_W-1:0]              reg_addr,
   input wire logic [31:0]                    reg_wdata,
   input wire logic                           reg_wr,
   input wire logic                           reg_rd,
   input wire logic [31:0]                    reg_rdata,
   // Serial side
   input wire logic [nsrf_pkg::NUM_PORTS-1:0]   rx_valid,
   input wire logic [nsrf_pkg::NUM_PORTS*8-1:0] rx_byte,
   input wire logic [nsrf_pkg::NUM_PORTS-1:0]   cts_line,
   input wire logic [nsrf_pkg::NUM_PORTS-1:0]   data_set_ready_line,
   // Read operation
   input wire logic                           rd_start,
   input wire nsrf_pkg::nsrf_rd_req_t         rd_req,
   input wire logic                           rd_done,
   input wire nsrf_pkg::nsrf_wr_t             mem_wr
);
   import nsrf_pkg::*;
   // ***
   // Tracking of the read in progress
   // ***
   logic        busy_r, zero_r, mon_r;
   logic [15:0] dest_r;
   logic [8:0]  cnt_r, wcnt_r;
   logic        take;
   assign take = rd_start && (!busy_r || rd_done);
   always_ff @(posedge clk) begin
      if (reset) begin
         busy_r <= 1'b0;
         zero_r <= 1'b0;
         mon_r  <= 1'b0;
         dest_r <= 16'h0000;
         cnt_r  <= 9'h000;
         wcnt_r <= 9'h000;
      end else if (take) begin
         busy_r <= 1'b1;
         zero_r <= rd_req.count == 9'h000 && rd_req.ctrl[7:4] == 4'h0;
         mon_r  <= rd_req.ctrl[7:4] inside {MON_CS, MON_DSR, MON_BOTH};
         dest_r <= rd_req.dest;
         cnt_r  <= rd_req.count;
         wcnt_r <= 9'h000;
      end else begin
         if (rd_done) busy_r <= 1'b0;
         if (mem_wr.we) wcnt_r <= wcnt_r + 9'h001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   done_bound_a: assert property (take |-> ##[1:300] rd_done)
      else $error("read did not finish in time");
   done_pulse_a: assert property (rd_done && !rd_start |=> !rd_done)
      else $error("done pulse longer than one cycle");
   zero_fast_a: assert property (take && rd_req.count == 9'h000 && rd_req.ctrl[7:4] == 4'h0
      |=> rd_done) else $error("zero count read not finished next cycle");
   zero_quiet_a: assert property (busy_r && zero_r |-> !mem_wr.we)
      else $error("zero count read wrote memory");
   mon_nodata_a: assert property (busy_r && mon_r && mem_wr.we |-> mem_wr.data[13:0] == 14'h0000)
      else $error("monitor read stored data bits");
   wr_inside_a: assert property (mem_wr.we |-> busy_r)
      else $error("memory write outside a read");
   wr_addr_a: assert property (mem_wr.we |-> mem_wr.addr == dest_r + {7'h00, wcnt_r})
      else $error("memory write address out of sequence");
   wr_total_a: assert property (rd_done && !mon_r |-> wcnt_r <= ({1'b0, cnt_r} + 10'h001) >> 1)
      else $error("more words written than requested");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside read cycle");
   cover property (take && zero_r == 1'b0 && rd_req.count == 9'h000);
   cover property (busy_r && mon_r && mem_wr.we);
   cover property (rd_done && !mon_r && wcnt_r > 9'h001);
endmodule

// [nsrf_dev_model.sv]
`timescale 1ns/1ps
module nsrf_dev_model (
   // Clock
   input wire logic                          clk,
   // Serial side toward the framer
   output logic [nsrf_pkg::NUM_PORTS-1:0]   rx_valid,
   output logic [nsrf_pkg::NUM_PORTS*8-1:0] rx_byte,
   output logic [nsrf_pkg::NUM_PORTS-1:0]   cts_line,
   output logic [nsrf_pkg::NUM_PORTS-1:0]   data_set_ready_line
);
   import nsrf_pkg::*;
   initial begin
      rx_valid            = 3'h0;
      rx_byte             = 24'hff_ffff;
      cts_line            = 3'h0;
      data_set_ready_line = 3'h0;
   end
   // One byte per strobe after an optional idle gap; lane shows the inverse afterwards
   task automatic send(input int p, input logic [7:0] b, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      rx_valid[p]       <= 1'b1;
      rx_byte[8*p +: 8] <= b;
      @(posedge clk);
      rx_valid[p]       <= 1'b0;
      rx_byte[8*p +: 8] <= ~b;
   endtask
   task automatic lines(input logic [2:0] c, input logic [2:0] d);
      @(posedge clk);
      cts_line            <= c;
      data_set_ready_line <= d;
   endtask
endmodule

// [test_noproto_serial_rx_framer.sv]
`timescale 1ns/1ps
module test_noproto_serial_rx_framer;
   import nsrf_pkg::*;
   logic                   clk, reset, reg_wr, reg_rd, rd_start, rd_done;
   logic [13:0]            reg_addr;
   logic [31:0]            reg_wdata, reg_rdata;
   logic [NUM_PORTS-1:0]   rx_valid, cts_line, data_set_ready_line;
   logic [NUM_PORTS*8-1:0] rx_byte;
   nsrf_rd_req_t           rd_req;
   nsrf_wr_t               mem_wr;
   logic [31:0]            lfsr = 32'h0000_8660;
   logic [15:0]            wq[$];
   logic [7:0]             b[3];
   int                     failures, checked, i;
   nsrf_rx_framer u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .cts_line(cts_line), .data_set_ready_line(data_set_ready_line),
      .rd_start(rd_start), .rd_req(rd_req), .rd_done(rd_done), .mem_wr(mem_wr));
   nsrf_dev_model u_dev (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .cts_line(cts_line), .data_set_ready_line(data_set_ready_line));
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) if (mem_wr.we === 1'b1) wq.push_back(mem_wr.data);
   // ***
   // Expectations and bus tasks
   // ***
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] pack(input logic [7:0] a, input logic [7:0] c, input logic sw);
      return sw ? {c, a} : {a, c};
   endfunction
   function automatic logic [15:0] mon_word(input logic [3:0] code, input logic c, input logic d);
      case (code)
         MON_CS: return {c, 15'h0000};
         MON_DSR: return {d, 15'h0000};
         default: return {c, d, 14'h0000};
      endcase
   endfunction
   function automatic logic [31:0] cfg(input logic [1:0] p, input logic se, input logic [7:0] sc,
                                       input nsrf_end_t em, input logic [7:0] ec,
                                       input logic [7:0] len);
      return {p, 3'h0, se, sc, em, ec, len};
   endfunction
   task automatic get_byte(output logic [7:0] v);
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0] | 8'h80;
   endtask
   task automatic close_out();
      $display("Counts: failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_mem(input string name, input logic [15:0] exp);
      chk(name, {16'h0000, exp}, (wq.size() > 0) ? {16'h0000, wq.pop_front()} : 32'hxxxx_xxxx);
   endtask
   task automatic reg_write(input logic [11:0] idx, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= {idx, 2'b00};
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic reg_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= {idx, 2'b00};
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk(name, exp, reg_rdata);
   endtask
   task automatic do_read(input logic [15:0] c, input logic [8:0] n, input logic [15:0] d);
      int k;
      wq.delete();
      @(posedge clk);
      rd_start <= 1'b1;
      rd_req   <= '{ctrl: c, count: n, dest: d};
      @(posedge clk);
      rd_start <= 1'b0;
      for (k = 0; k < 400; k++) begin
         #1;
         if (rd_done === 1'b1) break;
         @(posedge clk);
      end
      if (k == 400) begin
         failures++;
         $display("[ERR] read done expected 1 seen 0");
         close_out();
      end
      repeat (2) @(posedge clk);
   endtask
   // ***
   // Main sequence
   // ***
   initial begin
      reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 14'h0000; reg_wdata = 32'h0000_0000;
      rd_start = 1'b0; rd_req = '0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      reg_chk("flags after reset", IDX_SERIAL_RX_FLAGS, 32'h0000_0000);
      reg_chk("count after reset", IDX_PORT1_RX_COUNT, 32'h0000_0000);
      reg_chk("unmapped", 12'h0123, 32'h0000_0000);
      reg_write(IDX_FRAME_CFG, cfg(2'h0, 1'b0, 8'h00, NSRF_END_NONE, 8'h00, 8'h03));
      for (i = 0; i < 3; i++) begin
         get_byte(b[i]);
         u_dev.send(0, b[i], 3 * i);
      end
      reg_chk("fixed done", IDX_SERIAL_RX_FLAGS, 32'h0000_0040);
      reg_chk("fixed count", IDX_PORT1_RX_COUNT, 32'h0000_0003);
      u_dev.send(0, 8'h5a, 0);
      reg_write(IDX_SERIAL_RX_FLAGS, 32'h0000_0000);
      reg_chk("overflow", IDX_SERIAL_RX_FLAGS, 32'h0000_00c0);
      reg_chk("count held", IDX_PORT1_RX_COUNT, 32'h0000_0003);
      do_read(16'h0000, 9'h004, 16'h0100);
      chk_mem("word0", pack(b[0], b[1], 1'b0));
      chk_mem("word1 padded", {b[2], 8'h00});
      reg_chk("flags after read", IDX_SERIAL_RX_FLAGS, 32'h0000_0080);
      reg_chk("count after read", IDX_PORT1_RX_COUNT, 32'h0000_0000);
      do_read(16'h0000, 9'h000, 16'h0100);
      reg_chk("flags after zero read", IDX_SERIAL_RX_FLAGS, 32'h0000_0000);
      chk("zero read words", 32'h0000_0000, wq.size());
      reg_write(IDX_FRAME_CFG, cfg(2'h1, 1'b1, 8'h02, NSRF_END_BYTE, 8'h03, 8'h00));
      get_byte(b[0]);
      get_byte(b[1]);
      u_dev.send(1, 8'h41, 0);
      u_dev.send(1, 8'h02, 2);
      u_dev.send(1, b[0], 0);
      u_dev.send(1, b[1], 5);
      u_dev.send(1, 8'h03, 0);
      reg_chk("end code done", IDX_SERIAL_RX_FLAGS, 32'h0000_4000);
      reg_chk("codes not counted", IDX_PORT2_RX_COUNT, 32'h0000_0002);
      do_read(16'h0101, 9'h002, 16'h0200);
      chk_mem("swapped order", pack(b[0], b[1], 1'b1));
      reg_write(IDX_FRAME_CFG, cfg(2'h2, 1'b0, 8'h00, NSRF_END_CRLF, 8'h00, 8'h00));
      u_dev.send(2, b[0], 0);
      u_dev.send(2, CR_CODE, 0);
      u_dev.send(2, LF_CODE, 0);
      reg_chk("crlf done", IDX_EXT_PORT_RX_FLAGS, 32'h0000_0040);
      reg_chk("crlf count", IDX_EXT_PORT_RX_COUNT, 32'h0000_0001);
      reg_write(IDX_PORT_CTRL, 32'h0000_0004);
      reg_chk("restart flags", IDX_EXT_PORT_RX_FLAGS, 32'h0000_0000);
      reg_chk("restart count", IDX_EXT_PORT_RX_COUNT, 32'h0000_0000);
      for (i = 1; i <= 3; i++) begin
         get_byte(b[0]);
         u_dev.lines(b[0][2:0], b[0][5:3]);
         repeat (4) @(posedge clk);
         do_read({8'h00, i[3:0], 4'h0}, 9'h004, 16'h0300);
         chk("monitor words", 32'h0000_0001, wq.size());
         chk_mem("monitor", mon_word(i[3:0], b[0][0], b[0][3]));
      end
      reg_write(IDX_FRAME_CFG, cfg(2'h0, 1'b0, 8'h00, NSRF_END_NONE, 8'h00, 8'h00));
      for (i = 0; i < 256; i++) begin
         get_byte(b[2]);
         u_dev.send(0, b[2], 0);
         if (i == 254) reg_chk("not yet done", IDX_SERIAL_RX_FLAGS, 32'h0000_0000);
      end
      reg_chk("256 done", IDX_SERIAL_RX_FLAGS, 32'h0000_0040);
      reg_chk("256 count", IDX_PORT1_RX_COUNT, 32'h0000_0100);
      do_read(16'h0000, 9'h100, 16'h0400);
      chk("full frame words", 32'h0000_0080, wq.size());
      reg_write(IDX_FRAME_CFG, cfg(2'h2, 1'b0, 8'h00, NSRF_END_BYTE, 8'h03, 8'h00));
      for (i = 0; i < 257; i++) begin
         get_byte(b[2]);
         u_dev.send(2, b[2], 0);
         if (i == 255) reg_chk("256 no end", IDX_EXT_PORT_RX_FLAGS, 32'h0000_0040);
      end
      reg_chk("257 overflow", IDX_EXT_PORT_RX_FLAGS, 32'h0000_00c0);
      reg_chk("ext count held", IDX_EXT_PORT_RX_COUNT, 32'h0000_0100);
      close_out();
   end
endmodule
bind nsrf_rx_framer nsrf_rx_framer_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_byte(rx_byte), .cts_line(cts_line),
   .data_set_ready_line(data_set_ready_line), .rd_start(rd_start), .rd_req(rd_req),
   .rd_done(rd_done), .mem_wr(mem_wr));
